// file: design/bam_defs.vh
`ifndef BAM_DEFS_VH
`define BAM_DEFS_VH
// ==========================================================
// Register offsets (byte addresses)
`define BAM_REG_CTRL 8'h00
`define BAM_REG_STATUS 8'h04
`define BAM_REG_IRQ_STAT 8'h08
`define BAM_REG_IRQ_MASK 8'h0c
`define BAM_REG_ERRCODE 8'h10
`define BAM_REG_STATWORD 8'h14
`define BAM_REG_EMCY 8'h18
// ==========================================================
// Field positions
`define BAM_CTRL_SEL_BIT 0
`define BAM_ST_ALARM_BIT 0
`define BAM_ST_WARN_BIT 1
`define BAM_ST_MON_BIT 2
`define BAM_ST_SELACT_BIT 3
`define BAM_ST_ALMOUT_BIT 4
`define BAM_IRQ_ALARM_BIT 0
`define BAM_IRQ_WARN_BIT 1
`define BAM_IRQ_EMCY_BIT 2
`define BAM_SW_FAULT_BIT 3
// ==========================================================
// Reset values
`define BAM_CTRL_RST 1'b0
`define BAM_MASK_RST 3'h0
// ==========================================================
// Codes and timing
`define BAM_CODE_ALARM 16'h0830
`define BAM_CODE_WARN 16'h0930
`define BAM_CLK_HZ 20000000
`define BAM_ALM_OUT_S 5
`define BAM_MON_WIN_S 4
`define BAM_ALM_OUT_CYC (`BAM_ALM_OUT_S * `BAM_CLK_HZ)
`define BAM_MON_WIN_CYC (`BAM_MON_WIN_S * `BAM_CLK_HZ)
`define BAM_CHAR_MS 500
`define BAM_CHAR_CYC (`BAM_CHAR_MS * (`BAM_CLK_HZ / 1000))
`endif

// file: design/bam_code_rom.v
`timescale 1ns/100ps
// ==========================================================
// Display character table: step index to character code
module bam_code_rom (
  input wire clk_i, // Clock
  input wire warn_i, // Select warning code
  input wire [2:0] idx_i, // Character step
  output reg [7:0] char_o // Registered character
);
  always @(posedge clk_i) begin
    case (idx_i)
      3'h0: char_o <= 8'h41;
      3'h1: char_o <= 8'h2e;
      3'h2: char_o <= warn_i ? 8'h39 : 8'h38;
      3'h3: char_o <= 8'h33;
      3'h4: char_o <= 8'h30;
      default: char_o <= 8'h20;
    endcase
  end
endmodule // bam_code_rom

// file: design/bam_monitor.v
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/100ps
// What this block does
// - A battery indication at or under about 2.7 V gives the alarm or the warning only while the battery is watched, else neither.
// - The response select bit picks alarm (0, default) or warning (1) and acts after restart.
// - In alarm mode the servo alarm output runs up to five seconds, then a four-second watch.
// - In alarm mode no battery alarm is raised once the four-second watch has closed.
// - In warning mode the battery is watched continuously after the servo alarm output period.
// - The battery alarm stays latched until power is removed and reapplied.
// - An alarm shows its code on the front display one character at a time.
// - An alarm presents its active code to the operator unit.
// - Statusword bit 3 is 1 while an alarm is present and 0 otherwise.
// - The code of the active alarm is held in the error code register for the host.
// - An emergency message is sent to the network controller when an alarm occurs.
`include "bam_defs.vh"
module bam_monitor #(
  parameter ALM_OUT_CYC = `BAM_ALM_OUT_CYC,
  parameter MON_WIN_CYC = `BAM_MON_WIN_CYC,
  parameter CHAR_CYC = `BAM_CHAR_CYC
) (
  input wire clk_i, // 20 MHz clock
  input wire rst_i, // Sync reset, control power up
  input wire batt_low_i, // Battery at or under threshold
  input wire [31:0] wb_adr_i, // Wishbone address
  input wire [31:0] wb_dat_i, // Wishbone write data
  input wire [3:0] wb_sel_i, // Wishbone byte select
  input wire wb_we_i, // Wishbone write
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  output reg irq_o, // Level interrupt
  output reg servo_alarm_output_o, // Servo alarm pin
  output reg batt_alarm_o, // Latched battery alarm
  output reg batt_warn_o, // Battery warning
  output reg [7:0] disp_char_o, // Front display character
  output reg [15:0] op_code_o, // Operator unit alarm code
  output reg op_valid_o, // Operator unit code valid
  output reg fault_o, // Statusword fault bit
  output reg emcy_o // Emergency message pulse
);
  localparam ST_ALMOUT = 2'd0;
  localparam ST_WINDOW = 2'd1;
  localparam ST_CONT = 2'd2;
  localparam ST_IDLE = 2'd3;
  function [31:0] bam_mask;
    input [3:0] sel;
    begin
      bam_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction
  // Stored setting: survives a restart so that the new response can take effect after it
  reg ctrl_sel_q = `BAM_CTRL_RST;
  reg sel_act_q;
  reg [1:0] state_q;
  reg [31:0] cnt_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  reg [31:0] char_cnt_q;
  reg [2:0] char_idx_q;
  reg alarm_seen_q;
  reg warn_seen_q;
  wire [7:0] rom_char;
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire [31:0] wmask = bam_mask(wb_sel_i);
  wire [31:0] wdat = wb_dat_i & wmask;
  wire [7:0] adr = wb_adr_i[7:0];
  wire monitoring = (state_q == ST_WINDOW) | (state_q == ST_CONT);
  wire alarm_set = monitoring & ~sel_act_q & batt_low_i & ~batt_alarm_o;
  wire warn_rise = (state_q == ST_CONT) & batt_low_i & ~batt_warn_o;
  wire [2:0] ev = {alarm_set, warn_rise, alarm_set};
  wire any_on = batt_alarm_o | batt_warn_o;
  // ==========================================================
  // Start-up sequence
  always @(posedge clk_i) begin
    if (rst_i) begin
      sel_act_q <= `BAM_CTRL_RST;
      state_q <= ST_ALMOUT;
      cnt_q <= 32'h0;
      servo_alarm_output_o <= 1'b1;
    end else begin
      case (state_q)
        ST_ALMOUT: begin
          if (cnt_q == 32'h0)
            sel_act_q <= ctrl_sel_q;
          if (cnt_q >= ALM_OUT_CYC - 1) begin
            cnt_q <= 32'h0;
            servo_alarm_output_o <= 1'b0;
            state_q <= sel_act_q ? ST_CONT : ST_WINDOW;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_WINDOW: begin
          if (cnt_q >= MON_WIN_CYC - 1) begin
            cnt_q <= 32'h0;
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_CONT: state_q <= ST_CONT;
        ST_IDLE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Alarm and warning outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      batt_alarm_o <= 1'b0;
      batt_warn_o <= 1'b0;
      fault_o <= 1'b0;
      emcy_o <= 1'b0;
      op_code_o <= 16'h0;
      op_valid_o <= 1'b0;
    end else begin
      if (alarm_set)
        batt_alarm_o <= 1'b1;
      if (state_q == ST_CONT)
        batt_warn_o <= batt_low_i;
      fault_o <= batt_alarm_o | alarm_set;
      emcy_o <= alarm_set;
      op_valid_o <= any_on;
      if (batt_alarm_o)
        op_code_o <= `BAM_CODE_ALARM;
      else if (batt_warn_o)
        op_code_o <= `BAM_CODE_WARN;
      else
        op_code_o <= 16'h0;
    end
  end
  // ==========================================================
  // Front display sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      char_cnt_q <= 32'h0;
      char_idx_q <= 3'h0;
      disp_char_o <= 8'h20;
    end else if (!any_on) begin
      char_cnt_q <= 32'h0;
      char_idx_q <= 3'h0;
      disp_char_o <= 8'h20;
    end else begin
      disp_char_o <= rom_char;
      if (char_cnt_q >= CHAR_CYC - 1) begin
        char_cnt_q <= 32'h0;
        char_idx_q <= (char_idx_q == 3'h5) ? 3'h0 : char_idx_q + 3'h1;
      end else begin
        char_cnt_q <= char_cnt_q + 32'h1;
      end
    end
  end
  bam_code_rom u_rom (
    .clk_i(clk_i),
    .warn_i(~batt_alarm_o),
    .idx_i(char_idx_q),
    .char_o(rom_char)
  );
  // ==========================================================
  // Wishbone registers and interrupt
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      irq_stat_q <= 3'h0;
      irq_mask_q <= `BAM_MASK_RST;
      irq_o <= 1'b0;
      alarm_seen_q <= 1'b0;
      warn_seen_q <= 1'b0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h0;
      irq_o <= |(irq_stat_q & irq_mask_q);
      alarm_seen_q <= batt_alarm_o;
      warn_seen_q <= batt_warn_o;
      if (wr && adr == `BAM_REG_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~wdat[2:0]) | ev;
      else
        irq_stat_q <= irq_stat_q | ev;
      if (wr && adr == `BAM_REG_CTRL && wb_sel_i[0])
        ctrl_sel_q <= wb_dat_i[`BAM_CTRL_SEL_BIT];
      if (wr && adr == `BAM_REG_IRQ_MASK && wb_sel_i[0])
        irq_mask_q <= wb_dat_i[2:0];
      if (req && !wb_we_i) begin
        case (adr)
          `BAM_REG_CTRL: wb_dat_o <= {31'h0, ctrl_sel_q};
          `BAM_REG_STATUS: wb_dat_o <= {27'h0, servo_alarm_output_o, sel_act_q,
            monitoring, batt_warn_o, batt_alarm_o};
          `BAM_REG_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat_q};
          `BAM_REG_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask_q};
          `BAM_REG_ERRCODE: wb_dat_o <= {16'h0, op_code_o};
          `BAM_REG_STATWORD: wb_dat_o <= {28'h0, fault_o, 3'h0};
          `BAM_REG_EMCY: wb_dat_o <= {31'h0, alarm_seen_q};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end
endmodule // bam_monitor

// file: bench/bam_batt_model.sv
`timescale 1ns/100ps
// ==========================================================
// Backup battery: low indication, synchronous to the drive clock
module bam_batt_model (
  input wire logic clk_i, // Clock
  input wire logic drain_i, // Battery drained
  output logic batt_low_o // At or under threshold
);
  initial batt_low_o = 1'b0;
  always @(posedge clk_i) batt_low_o <= drain_i;
endmodule // bam_batt_model

// file: bench/bam_monitor_assertions.sv
`timescale 1ns/100ps
`include "bam_defs.vh"
// ==========================================================
// Port checks
module bam_monitor_assertions (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic batt_low_i, // Battery low
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_ack_o, // Ack
  input wire logic servo_alarm_output_o, // Alarm pin
  input wire logic batt_alarm_o, // Alarm
  input wire logic batt_warn_o, // Warning
  input wire logic [15:0] op_code_o, // Code
  input wire logic fault_o, // Fault
  input wire logic emcy_o // Emergency
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK: assert property (s_req |=> s_pulse) else $error("ack not one cycle");
  AST_ONE_KIND: assert property (!(batt_alarm_o && batt_warn_o)) else $error("both raised");
  AST_LATCH: assert property (batt_alarm_o |=> batt_alarm_o) else $error("alarm lost");
  AST_FAULT: assert property ($rose(batt_alarm_o) |=> fault_o) else $error("no fault");
  AST_NO_FLT: assert property (fault_o |-> batt_alarm_o) else $error("stray fault");
  AST_EMCY: assert property (emcy_o |=> !emcy_o && batt_alarm_o) else $error("bad emcy");
  AST_CODE: assert property (fault_o |-> ##[0:1] op_code_o == `BAM_CODE_ALARM)
    else $error("bad code");
  AST_WARN: assert property (batt_warn_o |-> $past(batt_low_i)) else $error("bad warn");
  AST_PIN: assert property (!servo_alarm_output_o |=> !servo_alarm_output_o)
    else $error("pin back");
endmodule // bam_monitor_assertions

// file: bench/tb_bam_monitor.sv
`timescale 1ns/100ps
`include "bam_defs.vh"
module tb_bam_monitor;
  logic clk_i = 0, rst_i = 1, drain = 0, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
  logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o, q;
  logic [3:0] wb_sel_i = 4'hf;
  logic batt_low_i, wb_ack_o, irq_o, servo_alarm_output_o, batt_alarm_o, batt_warn_o;
  logic fault_o, emcy_o, op_valid_o;
  logic [7:0] disp_char_o;
  logic [15:0] op_code_o;
  int fails = 0, check_count = 0, n;
  always #25 clk_i = ~clk_i;
  bam_batt_model u_batt (.clk_i, .drain_i(drain), .batt_low_o(batt_low_i));
  bam_monitor #(.ALM_OUT_CYC(20), .MON_WIN_CYC(20), .CHAR_CYC(4)) dut (.clk_i, .rst_i,
    .batt_low_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
    .wb_ack_o, .irq_o, .servo_alarm_output_o, .batt_alarm_o, .batt_warn_o, .disp_char_o,
    .op_code_o, .op_valid_o, .fault_o, .emcy_o);
  // ==========================================================
  // Tasks
  task end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= {24'h0, a};
    wb_dat_i <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    if (n >= 20) begin fails++; end_of_test; end
  endtask
  // Sel 0: pin low, 1: alarm or warning, 2: display shows A
  task wfor(input int sel, input int lim);
    n = 0;
    do begin @(posedge clk_i); n++; end
    while (!(sel == 0 ? servo_alarm_output_o === 1'b0 : sel == 1 ?
      (batt_alarm_o | batt_warn_o) === 1'b1 : disp_char_o === 8'h41) && n < lim);
    if (n >= lim) begin fails++; end_of_test; end
  endtask
  task restart;
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wfor(0, 40);
    chk("alarm pin time", n, 32'd21);
  endtask
  // ==========================================================
  // Tests
  initial begin
    restart;
    repeat (25) @(posedge clk_i);
    drain <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("late drop", {batt_alarm_o, batt_warn_o}, 2'b00);
    $display("Test late drop done");
    restart;
    wb(1'b1, `BAM_REG_IRQ_MASK, 32'h7);
    wfor(1, 30);
    drain <= 1'b0;
    chk("alarm", {batt_alarm_o, batt_warn_o}, 2'b10);
    wfor(2, 40);
    chk("display", disp_char_o, 8'h41);
    wb(1'b0, `BAM_REG_ERRCODE, 0);
    chk("error code", q, 32'h830);
    wb(1'b0, `BAM_REG_STATWORD, 0);
    chk("statusword", q[3], 1'b1);
    chk("operator", {op_valid_o, op_code_o}, 17'h10830);
    chk("irq", irq_o, 1'b1);
    wb(1'b0, `BAM_REG_IRQ_STAT, 0);
    chk("irq events", q, 32'h5);
    wb(1'b0, `BAM_REG_EMCY, 0);
    chk("emergency", q, 32'h1);
    wb(1'b1, `BAM_REG_IRQ_STAT, 32'h7);
    wb(1'b0, `BAM_REG_IRQ_STAT, 0);
    chk("irq status", q, 0);
    wb(1'b0, 8'h1c, 0);
    chk("unmapped", q, 0);
    chk("irq low", irq_o, 1'b0);
    chk("latched", batt_alarm_o, 1'b1);
    $display("Test alarm mode done");
    wb(1'b1, `BAM_REG_CTRL, 32'h1);
    wb(1'b0, `BAM_REG_STATUS, 0);
    chk("select early", q[3], 1'b0);
    restart;
    repeat (30) @(posedge clk_i);
    drain <= 1'b1;
    wfor(1, 10);
    chk("warning", {batt_alarm_o, batt_warn_o, irq_o}, 3'b010);
    wb(1'b0, `BAM_REG_STATUS, 0);
    chk("select late", q[3], 1'b1);
    chk("warn fault", fault_o, 1'b0);
    chk("warn code", op_code_o, 16'h0930);
    drain <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("warn cleared", batt_warn_o, 1'b0);
    $display("Test warning mode done");
    end_of_test;
  end
endmodule // tb_bam_monitor
bind bam_monitor bam_monitor_assertions u_chk (.clk_i, .rst_i, .batt_low_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .servo_alarm_output_o, .batt_alarm_o, .batt_warn_o, .op_code_o,
  .fault_o, .emcy_o);
